/* File: rtl/pctr_pkg.sv */
package pctr_pkg;
   // ----------------------------------------------------------------
   // register indices (printed offsets are not all multiples of four)
   // ----------------------------------------------------------------
   localparam logic [7:0] PCTR_IDX_CAP = 8'h35;
   localparam logic [7:0] PCTR_IDX_IDENT = 8'h37;
   localparam logic [7:0] PCTR_IDX_SLOT0 = 8'h39;
   localparam logic [7:0] PCTR_IDX_SLOT1 = 8'h3A;
   localparam logic [7:0] PCTR_IDX_ALIAS0 = 8'h40;
   localparam logic [7:0] PCTR_IDX_ALIAS1 = 8'h41;
   localparam logic [7:0] PCTR_IDX_HOLD0 = 8'h1E;
   localparam logic [7:0] PCTR_IDX_HOLD1 = 8'h1F;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int PCTR_CAP_FREEZE_BIT = 7;
   localparam int PCTR_CAP_SELFTEST_BIT = 5;
   localparam int PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT = 4;
   localparam int PCTR_CAP_PORT_MSB = 3;
   localparam int PCTR_IDENT_FREEZE_BIT = 0;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PCTR_CAP_RESET = 8'h00;
   localparam logic [7:0] PCTR_SLOT_RESET = 8'h00;
   localparam logic [7:0] PCTR_HOLD_RESET = 8'h00;
   // arbitrary neutral identifier value
   localparam logic [6:0] PCTR_IDENT_RESET = 7'h2A;
   localparam logic PCTR_IDENT_FREEZE_RESET = 1'b0;
   localparam logic [6:0] PCTR_ALIAS_RESET = 7'h00;
   localparam int PCTR_NSLOT = 2;
   localparam logic [31:0] PCTR_PSLVERR_NONE = 32'h0000_0000;
endpackage

/* File: rtl/pctr_remap.sv */
`timescale 1ns/1ps
`default_nettype none
module pctr_remap
   import pctr_pkg::*;
#(
   parameter int NSLOT = PCTR_NSLOT
)
(
   input wire logic [6:0] req_addr,
   input wire logic [NSLOT*7-1:0] alias_addr,
   input wire logic [NSLOT*7-1:0] target_addr,
   output logic [6:0] fwd_addr,
   output logic fwd_hit
);
   // lowest slot wins when two aliases collide
   always_comb
   begin
      fwd_addr = req_addr;
      fwd_hit = 1'b0;
      for (int i = NSLOT - 1; i >= 0; i--)
      begin
         if (alias_addr[i*7 +: 7] == req_addr &&
            alias_addr[i*7 +: 7] != 7'h00)
         begin
            fwd_addr = target_addr[i*7 +: 7];
            fwd_hit = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pctr_top.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - capability freeze bit blocks automatic reload of partner capability fields
// - frozen capabilities stay at software values in holding registers 0x1E/0x1F
// - self-test request bit shows partner asking for link self-test
// - after back channel link detect, auto-load self-test, multi-port, port
// - multi-port flag 0 single-port partner, 1 multi-port partner
// - four-bit port field gives partner port of this serializer
// - seven-bit partner identifier normally loaded from the partner
// - identifier freeze stops loading and keeps software value
// - slot zero holds seven-bit physical target address in bits 7:1
// - transaction to slot alias has address replaced by physical address
// - slot one gives same storage and remapping tied to alias one
module pctr_top
   import pctr_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_detected,
   input wire logic cap_load_valid,
   input wire logic cap_load_selftest,
   input wire logic cap_load_multi_port,
   input wire logic [3:0] cap_load_port,
   input wire logic ident_load_valid,
   input wire logic [6:0] ident_load_value,
   input wire logic [6:0] i2c_req_addr,
   output logic [6:0] i2c_fwd_addr,
   output logic i2c_fwd_hit,
   output logic link_selftest_request,
   output logic partner_multi_port_flag,
   output logic [3:0] partner_port,
   output logic [6:0] remote_deserializer_ident
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic capability_freeze;
   logic cap_reserved;
   logic cap_selftest;
   logic cap_partner_multi_port_flag;
   logic [3:0] cap_port;
   logic [7:0] hold0;
   logic [7:0] hold1;
   logic [6:0] ident;
   logic ident_freeze;
   logic [6:0] target_slot_zero_addr;
   logic [6:0] target_slot_one_addr;
   logic [6:0] alias0;
   logic [6:0] alias1;
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
   endfunction
   wire logic access = psel && penable;
   wire logic wr_lane0 = access && pwrite && pstrb[0];
   wire logic sel_cap = hit(paddr, PCTR_IDX_CAP);
   wire logic sel_ident = hit(paddr, PCTR_IDX_IDENT);
   wire logic sel_slot0 = hit(paddr, PCTR_IDX_SLOT0);
   wire logic sel_slot1 = hit(paddr, PCTR_IDX_SLOT1);
   wire logic sel_alias0 = hit(paddr, PCTR_IDX_ALIAS0);
   wire logic sel_alias1 = hit(paddr, PCTR_IDX_ALIAS1);
   wire logic sel_hold0 = hit(paddr, PCTR_IDX_HOLD0);
   wire logic sel_hold1 = hit(paddr, PCTR_IDX_HOLD1);
   wire logic sel_any = sel_cap || sel_ident || sel_slot0 || sel_slot1 ||
      sel_alias0 || sel_alias1 || sel_hold0 || sel_hold1;
   wire logic wr_cap = wr_lane0 && sel_cap;
   wire logic wr_ident = wr_lane0 && sel_ident;
   // automatic loads only once the back channel is up
   wire logic cap_auto = cap_load_valid && link_detected &&
      !capability_freeze;
   wire logic ident_auto = ident_load_valid && link_detected &&
      !ident_freeze;
   wire logic [7:0] cap_read = {capability_freeze, cap_reserved,
      cap_selftest, cap_partner_multi_port_flag, cap_port};
   wire logic [7:0] ident_read = {ident, ident_freeze};
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      if (sel_cap)
         next_rdata = cap_read;
      if (sel_ident)
         next_rdata = ident_read;
      if (sel_slot0)
         next_rdata = {target_slot_zero_addr, 1'b0};
      if (sel_slot1)
         next_rdata = {target_slot_one_addr, 1'b0};
      if (sel_alias0)
         next_rdata = {alias0, 1'b0};
      if (sel_alias1)
         next_rdata = {alias1, 1'b0};
      if (sel_hold0)
         next_rdata = hold0;
      if (sel_hold1)
         next_rdata = hold1;
   end
   // zero wait states: a simple bank has nothing to stall for
   assign pready = 1'b1;
   assign pslverr = access && !sel_any;
   assign prdata = {24'h000000, next_rdata};
   // ----------------------------------------------------------------
   // capability register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         capability_freeze <= PCTR_CAP_RESET[PCTR_CAP_FREEZE_BIT];
         cap_reserved <= PCTR_CAP_RESET[6];
         cap_selftest <= PCTR_CAP_RESET[PCTR_CAP_SELFTEST_BIT];
         cap_partner_multi_port_flag <= PCTR_CAP_RESET[PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT];
         cap_port <= PCTR_CAP_RESET[PCTR_CAP_PORT_MSB:0];
      end
      else if (wr_cap)
      begin
         // software wins over a coincident load
         capability_freeze <= pwdata[PCTR_CAP_FREEZE_BIT];
         cap_reserved <= pwdata[6];
         cap_selftest <= pwdata[PCTR_CAP_SELFTEST_BIT];
         cap_partner_multi_port_flag <= pwdata[PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT];
         cap_port <= pwdata[PCTR_CAP_PORT_MSB:0];
      end
      else if (cap_auto)
      begin
         cap_selftest <= cap_load_selftest;
         cap_partner_multi_port_flag <= cap_load_multi_port;
         cap_port <= cap_load_port;
      end
   end
   // ----------------------------------------------------------------
   // holding, identifier, slot and alias registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         hold0 <= PCTR_HOLD_RESET;
         hold1 <= PCTR_HOLD_RESET;
         target_slot_zero_addr <= PCTR_SLOT_RESET[7:1];
         target_slot_one_addr <= PCTR_SLOT_RESET[7:1];
         alias0 <= PCTR_ALIAS_RESET;
         alias1 <= PCTR_ALIAS_RESET;
      end
      else
      begin
         if (wr_lane0 && sel_hold0)
            hold0 <= pwdata[7:0];
         if (wr_lane0 && sel_hold1)
            hold1 <= pwdata[7:0];
         if (wr_lane0 && sel_slot0)
            target_slot_zero_addr <= pwdata[7:1];
         if (wr_lane0 && sel_slot1)
            target_slot_one_addr <= pwdata[7:1];
         if (wr_lane0 && sel_alias0)
            alias0 <= pwdata[7:1];
         if (wr_lane0 && sel_alias1)
            alias1 <= pwdata[7:1];
      end
   end
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         ident <= PCTR_IDENT_RESET;
         ident_freeze <= PCTR_IDENT_FREEZE_RESET;
      end
      else if (wr_ident)
      begin
         ident <= pwdata[7:1];
         ident_freeze <= pwdata[PCTR_IDENT_FREEZE_BIT];
      end
      else if (ident_auto)
         ident <= ident_load_value;
   end
   // ----------------------------------------------------------------
   // capabilities in effect
   // ----------------------------------------------------------------
   // while frozen, effect comes from the holding pair, not the live fields
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         link_selftest_request <= PCTR_CAP_RESET[PCTR_CAP_SELFTEST_BIT];
         partner_multi_port_flag <= PCTR_CAP_RESET[PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT];
         partner_port <= PCTR_CAP_RESET[PCTR_CAP_PORT_MSB:0];
         remote_deserializer_ident <= PCTR_IDENT_RESET;
      end
      else
      begin
         if (capability_freeze)
         begin
            link_selftest_request <= hold0[PCTR_CAP_SELFTEST_BIT];
            partner_multi_port_flag <= hold0[PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT];
            partner_port <= hold1[3:0];
         end
         else
         begin
            link_selftest_request <= cap_selftest;
            partner_multi_port_flag <= cap_partner_multi_port_flag;
            partner_port <= cap_port;
         end
         remote_deserializer_ident <= ident;
      end
   end
   // ----------------------------------------------------------------
   // alias remapping
   // ----------------------------------------------------------------
   pctr_remap #(.NSLOT(PCTR_NSLOT)) u_remap
   (
      .req_addr(i2c_req_addr),
      .alias_addr({alias1, alias0}),
      .target_addr({target_slot_one_addr, target_slot_zero_addr}),
      .fwd_addr(i2c_fwd_addr),
      .fwd_hit(i2c_fwd_hit)
   );
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_freeze_blocks;
      @(posedge core_clk) disable iff (reset)
      (capability_freeze && !wr_cap) |=> $stable(cap_port) && $stable(cap_partner_multi_port_flag);
   endproperty
   a_freeze_blocks: assert property (p_freeze_blocks)
      else $error("capability field changed while frozen");
   property p_hold_effect;
      @(posedge core_clk) disable iff (reset)
      capability_freeze |=> partner_port == $past(hold1[3:0]);
   endproperty
   a_hold_effect: assert property (p_hold_effect)
      else $error("frozen port not from holding register");
   property p_auto_load;
      @(posedge core_clk) disable iff (reset)
      (cap_auto && !wr_cap) |=> cap_selftest == $past(cap_load_selftest)
         && cap_port == $past(cap_load_port);
   endproperty
   a_auto_load: assert property (p_auto_load)
      else $error("auto load not applied");
   property p_no_load_without_link;
      @(posedge core_clk) disable iff (reset)
      (!link_detected && !wr_cap) |=> $stable(cap_selftest);
   endproperty
   a_no_load_without_link: assert property (p_no_load_without_link)
      else $error("load without link");
   property p_partner_multi_port_flag_effect;
      @(posedge core_clk) disable iff (reset)
      !capability_freeze ##1 !$past(capability_freeze)
         |-> partner_multi_port_flag == $past(cap_partner_multi_port_flag);
   endproperty
   a_partner_multi_port_flag_effect: assert property (p_partner_multi_port_flag_effect)
      else $error("multi-port flag mismatch");
   property p_ident_load;
      @(posedge core_clk) disable iff (reset)
      (ident_auto && !wr_ident) |=> ident == $past(ident_load_value);
   endproperty
   a_ident_load: assert property (p_ident_load)
      else $error("identifier not loaded");
   property p_ident_freeze;
      @(posedge core_clk) disable iff (reset)
      (ident_freeze && !wr_ident) |=> $stable(ident);
   endproperty
   a_ident_freeze: assert property (p_ident_freeze)
      else $error("identifier changed while frozen");
   property p_remap0;
      @(posedge core_clk) disable iff (reset)
      (i2c_req_addr == alias0 && alias0 != 0)
         |-> i2c_fwd_addr == target_slot_zero_addr;
   endproperty
   a_remap0: assert property (p_remap0)
      else $error("slot zero remap wrong");
   property p_remap1;
      @(posedge core_clk) disable iff (reset)
      (i2c_req_addr == alias1 && alias1 != 0 && alias1 != alias0)
         |-> i2c_fwd_addr == target_slot_one_addr;
   endproperty
   a_remap1: assert property (p_remap1)
      else $error("slot one remap wrong");
   property p_sw_wins;
      @(posedge core_clk) disable iff (reset)
      (wr_cap && cap_auto) |=> cap_port == $past(pwdata[3:0]);
   endproperty
   a_sw_wins: assert property (p_sw_wins)
      else $error("software write lost to auto load");
   property p_slot_write;
      @(posedge core_clk) disable iff (reset)
      (wr_lane0 && sel_slot0) |=> target_slot_zero_addr == $past(pwdata[7:1]);
   endproperty
   a_slot_write: assert property (p_slot_write)
      else $error("slot zero write lost");
   property p_selftest_effect;
      @(posedge core_clk) disable iff (reset)
      !capability_freeze |=> link_selftest_request == $past(cap_selftest);
   endproperty
   a_selftest_effect: assert property (p_selftest_effect)
      else $error("self-test request not from live field");
   property p_port_effect;
      @(posedge core_clk) disable iff (reset)
      !capability_freeze |=> partner_port == $past(cap_port);
   endproperty
   a_port_effect: assert property (p_port_effect)
      else $error("partner port not from live field");
   property p_hold_flags;
      @(posedge core_clk) disable iff (reset)
      capability_freeze |=>
         link_selftest_request == $past(hold0[PCTR_CAP_SELFTEST_BIT]) &&
         partner_multi_port_flag == $past(hold0[PCTR_CAP_PARTNER_MULTI_PORT_FLAG_BIT]);
   endproperty
   a_hold_flags: assert property (p_hold_flags)
      else $error("frozen flags not from holding register");
   property p_ident_effect;
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> remote_deserializer_ident == $past(ident);
   endproperty
   a_ident_effect: assert property (p_ident_effect)
      else $error("identifier output not from register");
   property p_slot1_write;
      @(posedge core_clk) disable iff (reset)
      (wr_lane0 && sel_slot1) |=> target_slot_one_addr == $past(pwdata[7:1]);
   endproperty
   a_slot1_write: assert property (p_slot1_write)
      else $error("slot one write lost");
   c_ident_frozen: cover property (@(posedge core_clk) disable iff (reset)
      ident_freeze && ident_load_valid && link_detected);
   c_auto: cover property (@(posedge core_clk) disable iff (reset) cap_auto);
   c_frozen: cover property (@(posedge core_clk) disable iff (reset)
      capability_freeze && cap_load_valid && link_detected);
   c_remap: cover property (@(posedge core_clk) disable iff (reset)
      i2c_fwd_hit);
   c_clash: cover property (@(posedge core_clk) disable iff (reset)
      wr_cap && cap_auto);
endmodule
`default_nettype wire

/* File: test/pctr_partner_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pctr_partner_model
(
   input wire logic core_clk,
   output logic link_detected,
   output logic cap_load_valid,
   output logic cap_load_selftest,
   output logic cap_load_multi_port,
   output logic [3:0] cap_load_port,
   output logic ident_load_valid,
   output logic [6:0] ident_load_value
);
   initial
   begin
      link_detected = 1'b0;
      cap_load_valid = 1'b0;
      cap_load_selftest = 1'b1;
      cap_load_multi_port = 1'b1;
      cap_load_port = 4'hF;
      ident_load_valid = 1'b0;
      ident_load_value = 7'h7F;
   end
   task automatic set_link(input logic up);
      @(posedge core_clk);
      link_detected <= up;
   endtask
   // ----------------------------------------------------------------
   // capability word; data scrambled outside the pulse so stale bits
   // can never pass for a fresh load
   // ----------------------------------------------------------------
   task automatic send_caps(input int dly, input logic st, input logic mp,
      input logic [3:0] port);
      repeat (dly) @(posedge core_clk);
      cap_load_valid <= 1'b1;
      cap_load_selftest <= st;
      cap_load_multi_port <= mp;
      cap_load_port <= port;
      @(posedge core_clk);
      cap_load_valid <= 1'b0;
      cap_load_selftest <= ~st;
      cap_load_multi_port <= ~mp;
      cap_load_port <= ~port;
   endtask
   task automatic send_ident(input logic [6:0] id);
      @(posedge core_clk);
      ident_load_valid <= 1'b1;
      ident_load_value <= id;
      @(posedge core_clk);
      ident_load_valid <= 1'b0;
      ident_load_value <= ~id;
   endtask
endmodule
`default_nettype wire

/* File: test/partner_caps_target_remap_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("ERROR %0t got %0h expected %0h", $time, got, exp); \
      end \
   end
module partner_caps_target_remap_tb_top;
   import pctr_pkg::*;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, partner_port, cap_load_port;
   logic link_detected, cap_load_valid, cap_load_selftest;
   logic cap_load_multi_port, ident_load_valid, i2c_fwd_hit;
   logic link_selftest_request, partner_multi_port_flag, err;
   logic [6:0] ident_load_value, i2c_req_addr, i2c_fwd_addr;
   logic [6:0] remote_deserializer_ident;
   int mismatches, n_checks;
   pctr_top uut (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_detected(link_detected), .cap_load_valid(cap_load_valid),
      .cap_load_selftest(cap_load_selftest),
      .cap_load_multi_port(cap_load_multi_port),
      .cap_load_port(cap_load_port), .ident_load_valid(ident_load_valid),
      .ident_load_value(ident_load_value), .i2c_req_addr(i2c_req_addr),
      .i2c_fwd_addr(i2c_fwd_addr), .i2c_fwd_hit(i2c_fwd_hit),
      .link_selftest_request(link_selftest_request),
      .partner_multi_port_flag(partner_multi_port_flag),
      .partner_port(partner_port),
      .remote_deserializer_ident(remote_deserializer_ident));
   pctr_partner_model partner (.core_clk(core_clk),
      .link_detected(link_detected), .cap_load_valid(cap_load_valid),
      .cap_load_selftest(cap_load_selftest),
      .cap_load_multi_port(cap_load_multi_port),
      .cap_load_port(cap_load_port), .ident_load_valid(ident_load_valid),
      .ident_load_value(ident_load_value));
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // apb master; byte address is four times the register index
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d, input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'hFFFFFF, d};
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // wait states end only when pready comes or the watchdog fires
      while (pready !== 1'b1)
         @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [11:0] ra(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, ra(idx), d, 4'hF);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, ra(idx), 8'h00, 4'hF);
      `CHK(rd, {24'h000000, e})
      `CHK(err, 1'b0)
   endtask
   task automatic eff(input logic st, input logic mp, input logic [3:0] p);
      repeat (2) @(posedge core_clk);
      `CHK({link_selftest_request, partner_multi_port_flag, partner_port},
         {st, mp, p})
   endtask
   task automatic t_reset();
      rchk(PCTR_IDX_CAP, PCTR_CAP_RESET);
      rchk(PCTR_IDX_IDENT, {PCTR_IDENT_RESET, PCTR_IDENT_FREEZE_RESET});
      rchk(PCTR_IDX_SLOT0, PCTR_SLOT_RESET);
      rchk(PCTR_IDX_SLOT1, PCTR_SLOT_RESET);
      eff(1'b0, 1'b0, 4'h0);
      `CHK(remote_deserializer_ident, PCTR_IDENT_RESET)
      apb(1'b0, 12'h0C4, 8'h00, 4'hF);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b0, 12'h0D5, 8'h00, 4'hF);
      `CHK(err, 1'b1)
   endtask
   task automatic t_autoload();
      partner.send_caps(1, 1'b1, 1'b1, 4'h9);
      rchk(PCTR_IDX_CAP, 8'h00);
      partner.set_link(1'b1);
      partner.send_caps(1, 1'b1, 1'b1, 4'hA);
      rchk(PCTR_IDX_CAP, 8'h3A);
      eff(1'b1, 1'b1, 4'hA);
      partner.send_caps(1, 1'b0, 1'b0, 4'h3);
      rchk(PCTR_IDX_CAP, 8'h03);
      eff(1'b0, 1'b0, 4'h3);
   endtask
   task automatic t_freeze();
      wr(PCTR_IDX_HOLD0, 8'h20);
      wr(PCTR_IDX_HOLD1, 8'h0C);
      wr(PCTR_IDX_CAP, 8'h80);
      partner.send_caps(1, 1'b0, 1'b1, 4'h5);
      rchk(PCTR_IDX_CAP, 8'h80);
      eff(1'b1, 1'b0, 4'hC);
   endtask
   task automatic t_ident();
      partner.send_ident(7'h11);
      rchk(PCTR_IDX_IDENT, 8'h22);
      `CHK(remote_deserializer_ident, 7'h11)
      wr(PCTR_IDX_IDENT, 8'h67);
      partner.send_ident(7'h44);
      rchk(PCTR_IDX_IDENT, 8'h67);
      `CHK(remote_deserializer_ident, 7'h33)
   endtask
   task automatic t_priority();
      wr(PCTR_IDX_CAP, 8'h00);
      // load pulse lands on the very edge that takes the write
      fork
         wr(PCTR_IDX_CAP, 8'h06);
         partner.send_caps(2, 1'b1, 1'b1, 4'hF);
      join
      rchk(PCTR_IDX_CAP, 8'h06);
   endtask
   task automatic t_remap();
      wr(PCTR_IDX_ALIAS0, 8'h40);
      wr(PCTR_IDX_ALIAS1, 8'h42);
      wr(PCTR_IDX_SLOT0, 8'hA1);
      wr(PCTR_IDX_SLOT1, 8'hC0);
      apb(1'b1, ra(PCTR_IDX_SLOT1), 8'hFF, 4'hE);
      rchk(PCTR_IDX_SLOT0, 8'hA0);
      rchk(PCTR_IDX_SLOT1, 8'hC0);
      i2c_req_addr <= 7'h20;
      @(posedge core_clk);
      `CHK({i2c_fwd_hit, i2c_fwd_addr}, {1'b1, 7'h50})
      i2c_req_addr <= 7'h21;
      @(posedge core_clk);
      `CHK({i2c_fwd_hit, i2c_fwd_addr}, {1'b1, 7'h60})
      i2c_req_addr <= 7'h22;
      @(posedge core_clk);
      `CHK(i2c_fwd_hit, 1'b0)
   endtask
   task automatic test_done();
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      i2c_req_addr = 7'h00;
      mismatches = 0;
      n_checks = 0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_autoload();
      t_freeze();
      t_ident();
      t_priority();
      t_remap();
      test_done();
   end
endmodule
`undef CHK
`default_nettype wire
